// ==== hdl/rivm_pkg.sv ====
package rivm_pkg;

    // ************************************************************
    // Widths and table figures
    // ************************************************************
    localparam int ADDR_W     = 12;               // Program word address width
    localparam int NUM_SRC    = 18;               // Interrupt sources, reset excluded
    localparam int SRC_IDX_W  = 5;                // Width of a source index
    localparam int CHG_CYCLES = 4;                // Change-enable window length

    // ************************************************************
    // Vector addresses
    // ************************************************************
    localparam logic [ADDR_W-1:0] RESET_VEC_ADDR = 12'h000; // Normal reset entry
    localparam logic [ADDR_W-1:0] FIRST_IRQ_ADDR = 12'h001; // External request zero
    localparam logic [ADDR_W-1:0] LAST_IRQ_ADDR  = 12'h012; // Program store ready
    localparam logic [ADDR_W-1:0] BOOT_ADDR_DEF  = 12'hC00; // Default boot reset address

    // ************************************************************
    // Fuse encoding
    // ************************************************************
    localparam logic FUSE_PROGRAMMED   = 1'h0;     // Boot reset selected
    localparam logic FUSE_UNPROGRAMMED = 1'h1;     // Normal reset selected

    // ************************************************************
    // Source bit positions, in vector order
    // ************************************************************
    localparam int SRC_EXT0  = 0;   // 0x001
    localparam int SRC_EXT1  = 1;   // 0x002
    localparam int SRC_T2CMP = 2;   // 0x003
    localparam int SRC_T2OVF = 3;   // 0x004
    localparam int SRC_T1CAP = 4;   // 0x005
    localparam int SRC_T1CA  = 5;   // 0x006
    localparam int SRC_T1CB  = 6;   // 0x007
    localparam int SRC_T1OVF = 7;   // 0x008
    localparam int SRC_T0OVF = 8;   // 0x009
    localparam int SRC_XFER  = 9;   // 0x00A transfer_complete
    localparam int SRC_RXC   = 10;  // 0x00B receive_complete
    localparam int SRC_TBE   = 11;  // 0x00C transmit_buffer_empty
    localparam int SRC_TXC   = 12;  // 0x00D transmit_complete
    localparam int SRC_CONV  = 13;  // 0x00E converter complete
    localparam int SRC_NVR   = 14;  // 0x00F nonvolatile_data_ready
    localparam int SRC_CMP   = 15;  // 0x010 comparator_event
    localparam int SRC_TWE   = 16;  // 0x011 two_wire_event
    localparam int SRC_PSR   = 17;  // 0x012 program_store_ready

    // ************************************************************
    // Carriers
    // ************************************************************
    // Control write from the core to the general_interrupt_control bits
    typedef struct packed {
        logic we;                    // Write strobe, one cycle
        logic vector_select;         // Value written to vector_select
        logic vector_change_enable;  // Value written to change enable
    } rivm_ctrl_wr_t;

    // Vector presented to the fetch unit
    typedef struct packed {
        logic              valid;    // Address valid this cycle
        logic [ADDR_W-1:0] addr;     // Program address
    } rivm_vec_t;

    // Change window state
    typedef enum logic [1:0] {
        CHG_IDLE = 2'b00,            // No sequence open
        CHG_OPEN = 2'b01,            // Change enable set, window counting
        CHG_HOLD = 2'b10             // Select written, block one instruction
    } rivm_chg_state_t;

endpackage

// ==== hdl/rivm_prio.sv ====
// ************************************************************
// Fixed priority encoder: lowest index wins
// ************************************************************
module rivm_prio #(
    parameter int N   = 18,
    parameter int IDX = 5
) (
    // Requests
    input  wire logic [N-1:0]   req,
    // Result
    output logic                any,
    output logic [IDX-1:0]      idx
);

    // Scan from the top so the lowest set bit is left last
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = IDX'(i);
            end
        end
    end

endmodule // rivm_prio

// ==== hdl/rivm_vector_map.sv ====
// Notes on behaviour
// - Reset enters at 0x000 with the fuse unprogrammed
// - External requests at 0x001 and 0x002
// - Seven timer vectors at 0x003 to 0x009
// - Serial transfer and three serial vectors 0x00A-0x00D
// - Converter to program-store-ready 0x00E to 0x012
// - Programmed fuse moves reset to boot address
// - Select bit adds boot start to vectors
// - Fuse sets reset, select sets vector base
// - Fuse one is normal, zero is boot
// - Change enable clears after four cycles or write
// - Servicing blocked during change window
module rivm_vector_map #(
    parameter logic [rivm_pkg::ADDR_W-1:0] BOOT_ADDR = rivm_pkg::BOOT_ADDR_DEF
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Fuse and control
    input  wire logic                          boot_reset_fuse,
    input  wire rivm_pkg::rivm_ctrl_wr_t       ctrl_wr,
    // Peripheral requests, already enabled and flagged
    input  wire logic [rivm_pkg::NUM_SRC-1:0]  irq_req,
    // Core handshake
    input  wire logic                          global_int_en,
    input  wire logic                          instr_done,
    input  wire logic                          irq_accept,
    // Outputs to the fetch unit
    output logic                               irq_pending,
    output rivm_pkg::rivm_vec_t                fetch_vec,
    output logic [rivm_pkg::SRC_IDX_W-1:0]     irq_ack_idx,
    output logic                               irq_ack,
    // Status
    output logic                               vector_select,
    output logic                               vector_change_enable
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam logic [2:0] CHG_LAST = 3'(rivm_pkg::CHG_CYCLES - 1); // Final window count

    logic                          fuse_s1_q;       // Fuse synchroniser stage one
    logic                          fuse_s2_q;       // Fuse synchroniser stage two
    logic                          fuse_cap_q;      // Fuse captured after reset
    logic                          fuse_cap_d;
    logic                          started_q;       // Reset vector issued
    logic                          started_d;
    logic                          sel_q;           // vector_select
    logic                          sel_d;
    rivm_pkg::rivm_chg_state_t     chg_q;           // Change window state
    rivm_pkg::rivm_chg_state_t     chg_d;
    logic [2:0]                    cnt_q;           // Window cycle count
    logic [2:0]                    cnt_d;
    rivm_pkg::rivm_vec_t           vec_q;           // Fetch address register
    rivm_pkg::rivm_vec_t           vec_d;
    logic [rivm_pkg::SRC_IDX_W-1:0] ack_idx_q;
    logic [rivm_pkg::SRC_IDX_W-1:0] ack_idx_d;
    logic                          ack_q;
    logic                          ack_d;
    logic                          blocked;         // Servicing held off
    logic                          win_any;         // Some request pending
    logic [rivm_pkg::SRC_IDX_W-1:0] win_idx;        // Winning source
    logic [rivm_pkg::ADDR_W-1:0]   reset_addr;      // Selected reset entry
    logic [rivm_pkg::ADDR_W-1:0]   vec_base;        // Selected vector base
    logic                          reset_pulse_q;   // One cycle after fuse capture

    // ************************************************************
    // Fuse synchroniser and capture
    // ************************************************************
    // Two stages with no reset, so the pin level is settled when reset releases
    always_ff @(posedge clk) begin
        fuse_s1_q <= boot_reset_fuse;
        fuse_s2_q <= fuse_s1_q;
    end

    // ************************************************************
    // Address selection
    // ************************************************************
    // Reset location from the fuse only, vector base from select only
    always_comb begin
        if (fuse_cap_q == rivm_pkg::FUSE_PROGRAMMED) begin
            reset_addr = BOOT_ADDR;
        end else begin
            reset_addr = rivm_pkg::RESET_VEC_ADDR;
        end
        vec_base = sel_q ? BOOT_ADDR : rivm_pkg::RESET_VEC_ADDR;
    end

    // ************************************************************
    // Request priority
    // ************************************************************
    // Bit order equals vector order, so lowest index is lowest address
    rivm_prio #(
        .N   (rivm_pkg::NUM_SRC),
        .IDX (rivm_pkg::SRC_IDX_W)
    ) u_prio (
        .req (irq_req),
        .any (win_any),
        .idx (win_idx)
    );

    // ************************************************************
    // Change window next state
    // ************************************************************
    always_comb begin
        chg_d = chg_q;
        cnt_d = cnt_q;
        sel_d = sel_q;
        case (chg_q)
            // Waiting for change enable to be set
            rivm_pkg::CHG_IDLE: begin
                if (ctrl_wr.we && ctrl_wr.vector_change_enable) begin
                    chg_d = rivm_pkg::CHG_OPEN;
                    cnt_d = 3'h0;
                end
            end
            // Select write clears change enable at once
            rivm_pkg::CHG_OPEN: begin
                if (ctrl_wr.we && !ctrl_wr.vector_change_enable) begin
                    sel_d = ctrl_wr.vector_select;
                    chg_d = rivm_pkg::CHG_HOLD;
                end else if (cnt_q == CHG_LAST) begin
                    chg_d = rivm_pkg::CHG_IDLE;
                end else begin
                    cnt_d = cnt_q + 3'h1;
                end
            end
            // Hold off until the next instruction completes
            rivm_pkg::CHG_HOLD: begin
                if (instr_done) begin
                    chg_d = rivm_pkg::CHG_IDLE;
                end
            end
            default: begin
                chg_d = rivm_pkg::CHG_IDLE;
            end
        endcase
    end

    // Interrupts blocked during the window; the global flag is untouched
    assign blocked = (chg_q != rivm_pkg::CHG_IDLE)
                   || (ctrl_wr.we && ctrl_wr.vector_change_enable);

    // ************************************************************
    // Fetch output next state
    // ************************************************************
    always_comb begin
        fuse_cap_d = fuse_cap_q;
        started_d  = 1'b1;
        vec_d      = '{valid: 1'b0, addr: vec_q.addr};
        ack_d      = 1'b0;
        ack_idx_d  = ack_idx_q;
        if (!started_q) begin
            // First cycle after release: capture fuse; reset entry is shown in the next cycle
            fuse_cap_d = fuse_s2_q;
        end
        if (started_q && irq_accept && irq_pending) begin
            vec_d.valid = 1'b1;
            vec_d.addr  = vec_base + rivm_pkg::FIRST_IRQ_ADDR
                        + rivm_pkg::ADDR_W'(win_idx);
            ack_d       = 1'b1;
            ack_idx_d   = win_idx;
        end
    end

    // Pending only when enabled, not blocked and past the first cycle after release
    assign irq_pending = started_q && win_any && global_int_en && !blocked;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fuse_cap_q <= rivm_pkg::FUSE_UNPROGRAMMED;
            started_q  <= 1'b0;
            sel_q      <= 1'b0;
            chg_q      <= rivm_pkg::CHG_IDLE;
            cnt_q      <= 3'h0;
            vec_q      <= '0;
            ack_q      <= 1'b0;
            ack_idx_q  <= '0;
        end else begin
            fuse_cap_q <= fuse_cap_d;
            started_q  <= started_d;
            sel_q      <= sel_d;
            chg_q      <= chg_d;
            cnt_q      <= cnt_d;
            vec_q      <= vec_d;
            ack_q      <= ack_d;
            ack_idx_q  <= ack_idx_d;
        end
    end

    // Reset entry is shown combinationally in the cycle after fuse capture
    always_comb begin
        fetch_vec = vec_q;
        if (started_q && !vec_q.valid && reset_pulse_q) begin
            fetch_vec.valid = 1'b1;
            fetch_vec.addr  = reset_addr;
        end
    end

    // Marks the single cycle in which the reset entry is shown
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reset_pulse_q <= 1'b0;
        end else begin
            reset_pulse_q <= !started_q;
        end
    end

    assign irq_ack              = ack_q;
    assign irq_ack_idx          = ack_idx_q;
    assign vector_select        = sel_q;
    assign vector_change_enable = (chg_q == rivm_pkg::CHG_OPEN);

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_chg_set;
        chg_q == rivm_pkg::CHG_IDLE && ctrl_wr.we && ctrl_wr.vector_change_enable;
    endsequence

    a_chg_timeout: assert property (@(posedge clk) disable iff (!nrst)
        s_chg_set ##1 (!ctrl_wr.we) [*4] |=> !vector_change_enable)
        else $error("change enable not cleared after four cycles");

    a_chg_blocks: assert property (@(posedge clk) disable iff (!nrst)
        vector_change_enable |-> !irq_pending)
        else $error("interrupt pending during change window");

    a_sel_write: assert property (@(posedge clk) disable iff (!nrst)
        vector_change_enable && ctrl_wr.we && !ctrl_wr.vector_change_enable
        |=> vector_select == $past(ctrl_wr.vector_select) && !vector_change_enable)
        else $error("select write not taken");

    a_vec_addr: assert property (@(posedge clk) disable iff (!nrst)
        irq_accept && irq_pending |=> fetch_vec.valid
        && fetch_vec.addr == 12'(((vector_select ? BOOT_ADDR : rivm_pkg::RESET_VEC_ADDR)
        + rivm_pkg::FIRST_IRQ_ADDR
        + 12'(irq_ack_idx))))
        else $error("vector address wrong");

    a_lowest_win: assert property (@(posedge clk) disable iff (!nrst)
        irq_accept && irq_pending && irq_req[0] |=> irq_ack_idx == '0)
        else $error("lowest source not served first");

    a_reset_addr: assert property (@(posedge clk) disable iff (!nrst)
        fetch_vec.valid && !irq_ack |-> fetch_vec.addr ==
        ((fuse_cap_q == rivm_pkg::FUSE_PROGRAMMED) ? BOOT_ADDR : rivm_pkg::RESET_VEC_ADDR))
        else $error("reset address wrong");

    a_reset_once: assert property (@(posedge clk) disable iff (!nrst)
        $rose(started_q) |-> fetch_vec.valid)
        else $error("reset vector not presented");

    a_hold_blocks: assert property (@(posedge clk) disable iff (!nrst)
        chg_q == rivm_pkg::CHG_HOLD |-> !irq_pending)
        else $error("interrupt during hold");

endmodule // rivm_vector_map

// ==== testbench/rivm_core_model.sv ====
// ************************************************************
// Core side model: instruction pacing and interrupt acceptance
// ************************************************************
module rivm_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Pace and arming from the bench
    input  wire logic [3:0] gap,
    input  wire logic       arm,
    // Handshake with the block
    input  wire logic       irq_pending,
    output logic            irq_accept,
    output logic            instr_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt_q;      // Cycles into the current instruction
    logic       taken_q;    // One accept per arming
    logic       go;         // Accept at this boundary

    // Accept only at an instruction boundary, once per arming
    assign go = arm && irq_pending && !taken_q && (cnt_q >= gap);

    // Outputs change on the falling edge, away from the sampling edge
    always @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q      <= 4'h0;
            taken_q    <= 1'b0;
            irq_accept <= 1'b0;
            instr_done <= 1'b0;
        end else begin
            cnt_q      <= (cnt_q >= gap) ? 4'h0 : cnt_q + 4'h1;
            instr_done <= (cnt_q >= gap);
            irq_accept <= go;
            taken_q    <= arm && (taken_q || go);
        end
    end
endmodule // rivm_core_model

// ==== testbench/tb_top.sv ====
// ************************************************************
// Self-checking bench for the vector map
// ************************************************************
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] BOOT_P = 12'hE00;   // Boot start under test

    logic                    clk, nrst, fuse, gie, arm, acc, done, pend, ack, vsel, vce;
    rivm_pkg::rivm_ctrl_wr_t ctrl;              // Control write
    rivm_pkg::rivm_vec_t     vec;               // Vector to fetch
    logic [17:0]             req;               // Source requests
    logic [4:0]              idx;               // Winning source
    logic [3:0]              gap;               // Core pace
    logic                    vvalid;            // Fetch valid as a plain bit
    int                      fail_count, compares, seed;

    rivm_vector_map #(.BOOT_ADDR(BOOT_P)) u_dut (
        .clk(clk), .nrst(nrst), .boot_reset_fuse(fuse), .ctrl_wr(ctrl), .irq_req(req),
        .global_int_en(gie), .instr_done(done), .irq_accept(acc), .irq_pending(pend),
        .fetch_vec(vec), .irq_ack_idx(idx), .irq_ack(ack), .vector_select(vsel),
        .vector_change_enable(vce));

    rivm_core_model u_core (
        .clk(clk), .nrst(nrst), .gap(gap), .arm(arm), .irq_pending(pend),
        .irq_accept(acc), .instr_done(done));

    assign vvalid = vec.valid;

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask

    // Counts, verdict, stop
    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One control write, strobe for one cycle
    task automatic wr(input logic s, input logic c);
        @(negedge clk);
        ctrl <= '{1'b1, s, c};
        @(negedge clk);
        ctrl <= '0;
    endtask

    // Wait for a flag under a bound
    task automatic wait_hi(ref logic f, input int lim);
        int n;
        n = 0;
        while (f !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    // Reset, then the reset entry must follow the fuse
    task automatic reset_with(input logic f);
        fuse <= f;
        nrst <= 1'b0;
        repeat (10) @(negedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        wait_hi(vvalid, 10);
        check(vec.valid, 1);
        check(vec.addr, (f === 1'b1) ? 12'h000 : BOOT_P);
        check(vsel, 0);
    endtask

    // Every source with random higher ones pending beside it
    task automatic run_irqs(input logic s);
        int          k, n, w;
        logic [17:0] one;
        int          exp_q[$];
        for (k = 0; k < 18; k++) begin
            one = 18'h1 << k;
            req <= one | (18'($random(seed)) & ~(one | (one - 18'h1)));
            arm <= 1'b1;
            @(negedge clk);
            w = 0;
            for (n = 17; n >= 0; n--) if (req[n]) w = n;
            exp_q.push_back((s ? int'(BOOT_P) : 0) + 1 + w);
            wait_hi(ack, 60);
            check(ack, 1);
            check(vec.valid, 1);
            check(idx, w);
            check(vec.addr, exp_q.pop_front());
            arm <= 1'b0;
            req <= '0;
            @(negedge clk);
        end
    endtask

    // Watchdog on the whole run
    initial begin
        #60000;
        fail_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        seed = 32'h0D05;
        nrst = 1'b0;
        fuse = 1'b1;
        gie = 1'b1;
        arm = 1'b0;
        gap = 4'h0;
        ctrl = '0;
        req = '0;
        fail_count = 0;
        compares = 0;
        reset_with(1'b1);
        reset_with(1'b0);
        run_irqs(1'b0);
        // Select write without change enable is ignored
        wr(1'b1, 1'b0);
        repeat (2) @(negedge clk);
        check(vsel, 0);
        // Window left to run out
        wr(1'b0, 1'b1);
        check(vce, 1);
        req <= 18'h1;
        repeat (4) begin
            check(pend, 0);
            check(vce, 1);
            @(negedge clk);
        end
        check(vce, 0);
        check(pend, 1);
        check(vsel, 0);
        // Full move to the boot section with a slow core
        gap <= 4'h5;
        wr(1'b0, 1'b1);
        wr(1'b1, 1'b0);
        check(vsel, 1);
        check(vce, 0);
        check(pend, 0);
        wait_hi(pend, 20);
        check(pend, 1);
        req <= '0;
        @(negedge clk);
        run_irqs(1'b1);
        // Global enable low refuses all
        gie <= 1'b0;
        req <= 18'h3;
        @(negedge clk);
        check(pend, 0);
        end_of_test();
    end
endmodule // tb_top
